// ### hdl/psf_host.sv
// host adapter pio setup handler with avalon-mm shadow registers
`timescale 1ns/100ps
`default_nettype none
module psf_host (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rx_valid,
  input  wire logic [31:0] rx_data,
  input  wire logic        rx_sof,
  input  wire logic        rx_eof,
  output logic             rx_ready,
  output logic             tx_valid,
  output logic [31:0]      tx_data,
  output logic             tx_sof,
  output logic             tx_eof,
  input  wire logic        tx_ready
);
  localparam int END_CYC = psf_pkg::E_STATUS_CYC;

  psf_pkg::psf_state_t state_reg;
  logic [4:0][31:0]    setup_dw;
  logic                setup_stb;
  logic                frame_err;
  logic                data_valid;
  logic                data_first;
  logic [31:0]         data_dword;
  logic                data_ready;
  logic                pk_ready;
  logic                pk_start;
  logic                ack_reg;
  logic                req;
  logic                is_data;
  logic                stall;
  logic                serve;
  logic                wr_take;
  logic                rd_take;
  logic                abort;
  logic                clr_err;
  logic                last_word;
  logic                s_dir;
  logic                payload_arrive;
  logic [15:0]         rd_word;
  logic [31:0]         rd_value;
  logic [15:0]         count_reg;
  logic                half_reg;
  logic [7:0]          status_reg;
  logic [7:0]          error_reg;
  logic [7:0]          held_status_reg;
  logic [7:0]          held_error_reg;
  logic [7:0]          held_estatus_reg;
  logic [31:0]         tf_lba_reg;
  logic [31:0]         tf_exp_reg;
  logic [7:0]          secx_reg;
  logic                dir_reg;
  logic                irq_reg;
  logic                ferr_reg;

  psf_rx_parse u_rx (
    .clock      (clock),
    .rstn       (rstn),
    .rx_valid   (rx_valid),
    .rx_data    (rx_data),
    .rx_sof     (rx_sof),
    .rx_eof     (rx_eof),
    .rx_ready   (rx_ready),
    .setup_stb  (setup_stb),
    .setup_dw   (setup_dw),
    .frame_err  (frame_err),
    .data_valid (data_valid),
    .data_first (data_first),
    .data_dword (data_dword),
    .data_ready (data_ready)
  );

  psf_tx_pack u_tx (
    .clock       (clock),
    .rstn        (rstn),
    .frame_start (pk_start),
    .in_valid    (wr_take),
    .in_word     (avs_writedata[15:0]),
    .in_last     (last_word),
    .in_ready    (pk_ready),
    .tx_valid    (tx_valid),
    .tx_data     (tx_data),
    .tx_sof      (tx_sof),
    .tx_eof      (tx_eof),
    .tx_ready    (tx_ready)
  );

  assign s_dir     = setup_dw[0][psf_pkg::DIR_BIT];
  assign last_word = (count_reg <= psf_pkg::BYTES_PER_WORD);
  assign pk_start  = setup_stb && !s_dir;
  assign payload_arrive = (state_reg == psf_pkg::ST_D2H_WAIT) && data_valid && data_first;

  // bus slave: at least one wait cycle, more while a data access stalls, then readdata stands with waitrequest low
  assign req     = (avs_read || avs_write) && !ack_reg;
  assign is_data = (avs_address == psf_pkg::REG_DATA);
  assign stall   = is_data && ((avs_read && (state_reg == psf_pkg::ST_D2H) && !data_valid)
                   || (avs_write && (state_reg == psf_pkg::ST_H2D) && !pk_ready));
  assign serve   = req && !stall && !setup_stb;
  assign avs_waitrequest = !ack_reg;
  assign wr_take = serve && avs_write && is_data && (state_reg == psf_pkg::ST_H2D);
  assign rd_take = serve && avs_read && is_data && (state_reg == psf_pkg::ST_D2H);
  assign abort   = serve && avs_write && (avs_address == psf_pkg::REG_CTRL)
                   && avs_writedata[psf_pkg::CTRL_ABORT_BIT];
  assign clr_err = serve && avs_write && (avs_address == psf_pkg::REG_CTRL)
                   && avs_writedata[psf_pkg::CTRL_CLRERR_BIT];

  always_comb
  begin
    case (state_reg)
      psf_pkg::ST_D2H:      data_ready = rd_take && (half_reg || last_word);
      psf_pkg::ST_D2H_WAIT: data_ready = 1'b0;
      default:              data_ready = 1'b1;
    endcase
  end

  assign rd_word = half_reg ? data_dword[31:16] : data_dword[15:0];

  always_comb
  begin
    case (avs_address)
      psf_pkg::REG_DATA:   rd_value = {16'h0000, (state_reg == psf_pkg::ST_D2H) ? rd_word : 16'h0000};
      psf_pkg::REG_STATUS: rd_value = {16'h0000, error_reg, status_reg};
      psf_pkg::REG_COUNT:  rd_value = {secx_reg, 4'h0, ferr_reg, (state_reg != psf_pkg::ST_IDLE),
                                       irq_reg, dir_reg, count_reg};
      psf_pkg::REG_TF_LBA: rd_value = tf_lba_reg;
      psf_pkg::REG_TF_EXP: rd_value = tf_exp_reg;
      default:             rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= serve;
      if (serve && avs_read)
        avs_readdata <= rd_value;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      state_reg <= psf_pkg::ST_IDLE;
    else if (setup_stb)
      state_reg <= s_dir ? psf_pkg::ST_D2H_WAIT : psf_pkg::ST_H2D;
    else if (abort)
      state_reg <= psf_pkg::ST_IDLE;
    else
    begin
      case (state_reg)
        psf_pkg::ST_H2D:
          if (wr_take && last_word)
            state_reg <= psf_pkg::ST_IDLE;
        psf_pkg::ST_D2H_WAIT:
          if (payload_arrive)
            state_reg <= psf_pkg::ST_D2H;
        psf_pkg::ST_D2H:
          if (rd_take && last_word)
            state_reg <= psf_pkg::ST_IDLE;
        default:
          state_reg <= psf_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      count_reg <= psf_pkg::COUNT_RST;
    else if (setup_stb)
      count_reg <= setup_dw[4][15:0];
    else if (abort)
      count_reg <= psf_pkg::COUNT_RST;
    else if (wr_take || rd_take)
      count_reg <= last_word ? 16'h0000 : count_reg - psf_pkg::BYTES_PER_WORD;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      half_reg <= 1'b0;
    else if (setup_stb || abort)
      half_reg <= 1'b0;
    // tracks the word half in both directions, mirrors the packer on writes
    else if (rd_take || wr_take)
      half_reg <= !half_reg && !last_word;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      held_status_reg  <= psf_pkg::STATUS_RST;
      held_error_reg   <= 8'h00;
      held_estatus_reg <= psf_pkg::STATUS_RST;
    end
    else if (setup_stb)
    begin
      held_status_reg  <= setup_dw[0][psf_pkg::STATUS_LSB +: 8];
      held_error_reg   <= setup_dw[0][psf_pkg::ERROR_LSB +: 8];
      held_estatus_reg <= setup_dw[3][psf_pkg::ESTATUS_LSB +: 8];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      status_reg <= psf_pkg::STATUS_RST;
      error_reg  <= 8'h00;
    end
    else if (pk_start)
    begin
      status_reg <= setup_dw[0][psf_pkg::STATUS_LSB +: 8];
      error_reg  <= setup_dw[0][psf_pkg::ERROR_LSB +: 8];
    end
    else if (payload_arrive && !abort)
    begin
      status_reg <= held_status_reg;
      error_reg  <= held_error_reg;
    end
    else if ((wr_take || rd_take) && last_word)
      status_reg <= held_estatus_reg;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      tf_lba_reg <= 32'h0000_0000;
      tf_exp_reg <= 32'h0000_0000;
      secx_reg   <= 8'h00;
      dir_reg    <= 1'b0;
      irq_reg    <= 1'b0;
    end
    else if (setup_stb)
    begin
      tf_lba_reg <= setup_dw[1];
      tf_exp_reg <= {setup_dw[3][7:0], setup_dw[2][23:0]};
      secx_reg   <= setup_dw[3][15:8];
      dir_reg    <= s_dir;
      irq_reg    <= setup_dw[0][psf_pkg::IRQ_BIT];
    end
  end

  // a malformed frame sets this; a clear in the same cycle loses
  always_ff @(posedge clock)
  begin
    if (!rstn)
      ferr_reg <= 1'b0;
    else if (frame_err)
      ferr_reg <= 1'b1;
    else if (clr_err)
      ferr_reg <= 1'b0;
  end

  h2d_shadow_a: assert property (@(posedge clock) disable iff (!rstn)
    setup_stb && !s_dir |=> status_reg == $past(setup_dw[0][23:16])
    && error_reg == $past(setup_dw[0][31:24]) && state_reg == psf_pkg::ST_H2D)
    else $error("host-to-device setup did not update shadows");
  d2h_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    setup_stb && s_dir |=> status_reg == $past(status_reg)
    && held_estatus_reg == $past(setup_dw[3][31:24]) && state_reg == psf_pkg::ST_D2H_WAIT)
    else $error("device-to-host setup changed shadows too early");
  count_load_a: assert property (@(posedge clock) disable iff (!rstn)
    setup_stb |=> count_reg == $past(setup_dw[4][15:0]))
    else $error("countdown not loaded from transfer count");
  write_dec_a: assert property (@(posedge clock) disable iff (!rstn)
    wr_take && !last_word |=> count_reg == $past(count_reg) - 16'h0002 && tx_valid == $past(half_reg))
    else $error("data write did not decrement countdown");
  read_dec_a: assert property (@(posedge clock) disable iff (!rstn)
    rd_take && !last_word |=> count_reg == $past(count_reg) - 16'h0002 && avs_readdata[15:0] == $past(rd_word))
    else $error("data read did not decrement countdown");
  end_status_a: assert property (@(posedge clock) disable iff (!rstn)
    (wr_take || rd_take) && last_word |-> ##[1:END_CYC] status_reg == held_estatus_reg && count_reg == 16'h0000)
    else $error("ending status late at terminal count");
  payload_move_a: assert property (@(posedge clock) disable iff (!rstn)
    payload_arrive && !setup_stb && !abort |=> status_reg == $past(held_status_reg)
    && error_reg == $past(held_error_reg) && state_reg == psf_pkg::ST_D2H)
    else $error("payload arrival did not move held status");
  tx_header_a: assert property (@(posedge clock) disable iff (!rstn)
    pk_start |=> tx_valid && tx_sof && tx_data[7:0] == psf_pkg::TYPE_DATA)
    else $error("payload frame missing its header");
  frame_err_a: assert property (@(posedge clock) disable iff (!rstn)
    frame_err |=> ferr_reg)
    else $error("malformed frame did not set the error flag");
  one_payload_a: assert property (@(posedge clock) disable iff (!rstn)
    (wr_take || rd_take) && last_word |=> state_reg == psf_pkg::ST_IDLE)
    else $error("transfer did not end at terminal count");
  d2h_wait_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == psf_pkg::ST_D2H_WAIT && data_valid |-> !rx_ready)
    else $error("payload data taken before status moved");
endmodule // psf_host
`default_nettype wire

// ### hdl/psf_pkg.sv
// shared constants for the pio setup frame handler
`default_nettype none
package psf_pkg;
  // frame type codes and lengths
  localparam logic [7:0]  TYPE_SETUP     = 8'h5f;
  localparam logic [7:0]  TYPE_DATA      = 8'h46;
  localparam logic [11:0] SETUP_LAST_IDX = 12'h004;
  localparam logic [11:0] DATA_MAX_DW    = 12'h800;
  // setup frame field positions
  localparam int DIR_BIT     = 13;
  localparam int IRQ_BIT     = 14;
  localparam int STATUS_LSB  = 16;
  localparam int ERROR_LSB   = 24;
  localparam int ESTATUS_LSB = 24;
  // shadow status flags
  localparam int BUSY_BIT = 7;
  localparam int DRQ_BIT  = 3;
  // register byte offsets
  localparam logic [4:0] REG_DATA   = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_COUNT  = 5'h08;
  localparam logic [4:0] REG_TF_LBA = 5'h0c;
  localparam logic [4:0] REG_TF_EXP = 5'h10;
  localparam logic [4:0] REG_CTRL   = 5'h14;
  // control and count register fields
  localparam int CTRL_ABORT_BIT  = 0;
  localparam int CTRL_CLRERR_BIT = 1;
  localparam int CNT_DIR_BIT     = 16;
  localparam int CNT_IRQ_BIT     = 17;
  localparam int CNT_ACTIVE_BIT  = 18;
  localparam int CNT_FERR_BIT    = 19;
  localparam int CNT_SECX_LSB    = 24;
  // reset values and bytes per data word
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] BYTES_PER_WORD = 16'h0002;
  // ending status must land within this time of terminal count
  localparam int E_STATUS_NS  = 400;
  localparam int CLK_NS       = 20;
  localparam int E_STATUS_CYC = (E_STATUS_NS / CLK_NS) < 1 ? 1 : (E_STATUS_NS / CLK_NS);
  typedef enum logic [1:0] {ST_IDLE, ST_H2D, ST_D2H_WAIT, ST_D2H} psf_state_t;
endpackage
`default_nettype wire

// ### hdl/psf_rx_parse.sv
// receive-side frame parser: captures setup frames, passes payload dwords
`timescale 1ns/100ps
`default_nettype none
module psf_rx_parse (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             rx_valid,
  input  wire logic [31:0]      rx_data,
  input  wire logic             rx_sof,
  input  wire logic             rx_eof,
  output logic                  rx_ready,
  output logic                  setup_stb,
  output logic [4:0][31:0]      setup_dw,
  output logic                  frame_err,
  output logic                  data_valid,
  output logic                  data_first,
  output logic [31:0]           data_dword,
  input  wire logic             data_ready
);
  logic [11:0] idx_reg;
  logic [7:0]  ftype_reg;
  logic        in_frame_reg;
  logic        take;
  logic        body;
  logic        framed;
  logic [11:0] cur_idx;
  logic [7:0]  cur_type;

  assign cur_idx    = rx_sof ? 12'h000 : idx_reg;
  assign cur_type   = rx_sof ? rx_data[7:0] : ftype_reg;
  assign framed     = rx_sof || in_frame_reg;
  assign body       = !rx_sof && in_frame_reg && (ftype_reg == psf_pkg::TYPE_DATA);
  // stalls the link only inside a payload body, so software sets the pace
  assign rx_ready   = body ? data_ready : 1'b1;
  assign take       = rx_valid && rx_ready;
  assign data_valid = rx_valid && body;
  assign data_first = (idx_reg == 12'h001);
  assign data_dword = rx_data;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      idx_reg      <= 12'h000;
      ftype_reg    <= 8'h00;
      in_frame_reg <= 1'b0;
    end
    else if (take && framed)
    begin
      ftype_reg    <= cur_type;
      in_frame_reg <= !rx_eof;
      if (cur_idx != 12'hfff)
        idx_reg <= cur_idx + 12'h001;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : g_cap
      always_ff @(posedge clock)
      begin
        if (!rstn)
          setup_dw[g] <= 32'h0000_0000;
        else if (take && framed && (cur_type == psf_pkg::TYPE_SETUP) && (cur_idx == 12'(g)))
          setup_dw[g] <= rx_data;
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      setup_stb <= 1'b0;
      frame_err <= 1'b0;
    end
    else
    begin
      setup_stb <= take && framed && rx_eof && (cur_type == psf_pkg::TYPE_SETUP)
                   && (cur_idx == psf_pkg::SETUP_LAST_IDX);
      frame_err <= take && framed && rx_eof
                   && (((cur_type == psf_pkg::TYPE_SETUP) && (cur_idx != psf_pkg::SETUP_LAST_IDX))
                   || ((cur_type == psf_pkg::TYPE_DATA)
                   && ((cur_idx == 12'h000) || (cur_idx > psf_pkg::DATA_MAX_DW))));
    end
  end

  setup_len_a: assert property (@(posedge clock) disable iff (!rstn)
    setup_stb |-> $past(cur_idx) == psf_pkg::SETUP_LAST_IDX && $past(cur_type) == psf_pkg::TYPE_SETUP)
    else $error("setup strobe without a five dword setup frame");
endmodule // psf_rx_parse
`default_nettype wire

// ### hdl/psf_tx_pack.sv
// transmit-side packer: 16-bit words into dwords of one payload frame
`timescale 1ns/100ps
`default_nettype none
module psf_tx_pack (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        frame_start,
  input  wire logic        in_valid,
  input  wire logic [15:0] in_word,
  input  wire logic        in_last,
  output logic             in_ready,
  output logic             tx_valid,
  output logic [31:0]      tx_data,
  output logic             tx_sof,
  output logic             tx_eof,
  input  wire logic        tx_ready
);
  logic [15:0] lo_reg;
  logic        have_lo_reg;
  logic        in_take;

  // one dword of holding only; a slow link back-pressures software writes
  assign in_ready = !tx_valid;
  assign in_take  = in_valid && in_ready;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      tx_valid <= 1'b0;
      tx_data  <= 32'h0000_0000;
      tx_sof   <= 1'b0;
      tx_eof   <= 1'b0;
    end
    else if (frame_start)
    begin
      tx_valid <= 1'b1;
      tx_data  <= {24'h00_0000, psf_pkg::TYPE_DATA};
      tx_sof   <= 1'b1;
      tx_eof   <= 1'b0;
    end
    else if (in_take && (have_lo_reg || in_last))
    begin
      tx_valid <= 1'b1;
      tx_data  <= have_lo_reg ? {in_word, lo_reg} : {16'h0000, in_word};
      tx_sof   <= 1'b0;
      tx_eof   <= in_last;
    end
    else if (tx_ready)
      tx_valid <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      lo_reg      <= 16'h0000;
      have_lo_reg <= 1'b0;
    end
    else if (frame_start)
      have_lo_reg <= 1'b0;
    else if (in_take)
    begin
      lo_reg      <= in_word;
      have_lo_reg <= !have_lo_reg && !in_last;
    end
  end

  odd_pad_a: assert property (@(posedge clock) disable iff (!rstn)
    in_take && in_last && !have_lo_reg && !frame_start |=> tx_valid && tx_data[31:16] == 16'h0000)
    else $error("odd last word not padded with zeros");
  frame_close_a: assert property (@(posedge clock) disable iff (!rstn)
    in_take && in_last && !frame_start |=> tx_valid && tx_eof && !tx_sof)
    else $error("payload frame not closed on last word");
endmodule // psf_tx_pack
`default_nettype wire

// ### sim/psf_dev_model.sv
// device-side model: sends setup and payload frames, sinks the host payload
`timescale 1ns/100ps
`default_nettype none
module psf_dev_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  output logic             rx_valid,
  output logic [31:0]      rx_data,
  output logic             rx_sof,
  output logic             rx_eof,
  input  wire logic        rx_ready,
  input  wire logic        tx_valid,
  input  wire logic [31:0] tx_data,
  input  wire logic        tx_sof,
  input  wire logic        tx_eof,
  output logic             tx_ready
);
  logic [33:0] tx_q[$];
  logic        slow    = 1'b0;
  logic [31:0] cmd_dw1 = 32'he0a1b2c3;
  logic [23:0] lba_x   = 24'h0d0e0f;
  logic [7:0]  sec     = 8'h03;
  logic [7:0]  sec_x   = 8'h5a;
  initial
  begin
    {rx_valid, rx_sof, rx_eof, rx_data, tx_ready} = '0;
  end
  // accept host payload; slow mode stalls every other cycle
  always @(posedge clock)
  begin
    if (rstn && tx_valid && tx_ready)
      tx_q.push_back({tx_eof, tx_sof, tx_data});
    tx_ready <= rstn && (!slow || !tx_ready);
  end
  // released data lines show the inverse so a stale value never looks valid
  task automatic put(input logic [31:0] d, input logic s, input logic e);
    @(posedge clock);
    {rx_valid, rx_sof, rx_eof, rx_data} <= {1'b1, s, e, d};
    do @(posedge clock); while (rx_ready !== 1'b1);
    {rx_valid, rx_sof, rx_eof, rx_data} <= {3'b000, ~d};
  endtask
  task automatic send(input logic [31:0] q[$]);
    for (int i = 0; i < q.size(); i++)
      put(q[i], i == 0, i == q.size() - 1);
  endtask
  // whole transfer in one frame after a 46h header
  task automatic payload(input logic [31:0] d[$]);
    d.push_front({24'h0, psf_pkg::TYPE_DATA});
    send(d);
  endtask
  task automatic setup(input logic dir, input logic irq, input logic [7:0] st, input logic [7:0] er,
                       input logic [7:0] est, input logic [15:0] cnt);
    send('{{er, st, 1'b0, irq, dir, 5'h00, psf_pkg::TYPE_SETUP}, cmd_dw1, {8'h00, lba_x},
           {est, 8'h00, sec_x, sec}, {16'h0000, cnt}});
  endtask
endmodule // psf_dev_model
`default_nettype wire

// ### sim/test_psf_host.sv
// self-checking testbench for the pio setup frame handler
`timescale 1ns/100ps
`default_nettype none
module test_psf_host;
  logic        clock         = 1'b0;
  logic        rstn          = 1'b0;
  logic [4:0]  avs_address   = 5'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rx_data, tx_data, rd;
  logic        avs_waitrequest, rx_valid, rx_sof, rx_eof, rx_ready, tx_valid, tx_sof, tx_eof, tx_ready;
  logic [15:0] h2d_w[3]      = '{16'h1111, 16'h2222, 16'h3333};
  int          errors        = 0;
  int          tests_run     = 0;
  int          cycles        = 0;
  always #10 clock = ~clock;
  psf_host i_dut (.clock(clock), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof),
    .rx_eof(rx_eof), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_sof(tx_sof),
    .tx_eof(tx_eof), .tx_ready(tx_ready));
  psf_dev_model i_dev (.clock(clock), .rstn(rstn), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_sof(tx_sof), .tx_eof(tx_eof), .tx_ready(tx_ready));
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    @(posedge clock);
    {avs_write, avs_read, avs_address, avs_writedata} <= {wr, !wr, a, wd};
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    {avs_write, avs_read} <= 2'b00;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
    bus(1'b0, a, 32'h0);
    check(what, {2'b00, rd & m}, {2'b00, e});
  endtask
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      test_done;
    end
  end
  initial
  begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rd_chk(psf_pkg::REG_STATUS, 32'hffffffff, 32'h0, "reset status");
    rd_chk(psf_pkg::REG_COUNT, 32'hffffffff, 32'h0, "reset count");
    rd_chk(5'h18, 32'hffffffff, 32'h0, "unmapped");
    $display("test reset done");
    i_dev.slow <= 1'b1;
    i_dev.setup(1'b0, 1'b0, 8'h58, 8'h01, 8'h50, 16'h0006);
    repeat (3) @(posedge clock);
    rd_chk(psf_pkg::REG_STATUS, 32'hffffffff, 32'h0158, "h2d status");
    rd_chk(psf_pkg::REG_COUNT, 32'hffffffff, {i_dev.sec_x, 24'h040006}, "h2d count");
    rd_chk(psf_pkg::REG_TF_LBA, 32'hffffffff, i_dev.cmd_dw1, "taskfile");
    rd_chk(psf_pkg::REG_TF_EXP, 32'hffffffff, {i_dev.sec, i_dev.lba_x}, "taskfile exp");
    foreach (h2d_w[i]) bus(1'b1, psf_pkg::REG_DATA, {16'h0, h2d_w[i]});
    rd_chk(psf_pkg::REG_STATUS, 32'hff, 32'h50, "h2d end status");
    rd_chk(psf_pkg::REG_COUNT, 32'hffff, 32'h0, "h2d count end");
    repeat (20) if (i_dev.tx_q.size() < 3) @(posedge clock);
    check("tx header", i_dev.tx_q[0], {2'b01, 24'h0, psf_pkg::TYPE_DATA});
    check("tx dword", i_dev.tx_q[1], {2'b00, 32'h22221111});
    check("tx last", i_dev.tx_q[2], {2'b10, 32'h00003333});
    check("tx length", 34'(i_dev.tx_q.size()), 34'h3);
    $display("test h2d done");
    i_dev.slow <= 1'b0;
    i_dev.setup(1'b1, 1'b1, 8'h58, 8'h00, 8'h48, 16'h0004);
    repeat (3) @(posedge clock);
    rd_chk(psf_pkg::REG_STATUS, 32'hffffffff, 32'h0150, "d2h held");
    rd_chk(psf_pkg::REG_COUNT, 32'h0007ffff, 32'h00070004, "d2h count");
    fork
      i_dev.payload('{32'hbeef1234});
      begin
        repeat (8) @(posedge clock);
        rd_chk(psf_pkg::REG_STATUS, 32'hffffffff, 32'h0058, "d2h status");
        rd_chk(psf_pkg::REG_DATA, 32'hffff, 32'h1234, "d2h low");
        rd_chk(psf_pkg::REG_COUNT, 32'hffff, 32'h2, "d2h count half");
        rd_chk(psf_pkg::REG_DATA, 32'hffff, 32'hbeef, "d2h high");
      end
    join
    rd_chk(psf_pkg::REG_STATUS, 32'hffffffff, 32'h0048, "d2h end status");
    $display("test d2h done");
    i_dev.send('{{24'h0, psf_pkg::TYPE_SETUP}, 32'h0, 32'h0, 32'h0});
    repeat (3) @(posedge clock);
    rd_chk(psf_pkg::REG_COUNT, 32'h00080000, 32'h00080000, "short setup");
    bus(1'b1, psf_pkg::REG_CTRL, 32'h2);
    rd_chk(psf_pkg::REG_COUNT, 32'h00080000, 32'h0, "error cleared");
    $display("test frame error done");
    i_dev.setup(1'b0, 1'b0, 8'h58, 8'h00, 8'h50, 16'h0004);
    repeat (3) @(posedge clock);
    bus(1'b1, psf_pkg::REG_CTRL, 32'h1);
    rd_chk(psf_pkg::REG_COUNT, 32'h0004ffff, 32'h0, "abort");
    $display("test abort done");
    test_done;
  end
endmodule // test_psf_host
`default_nettype wire
